// *** shared/tbam_pkg.sv ***
// Purpose: Shared constants and types of the ten-bit address match slave
// Assumes: 16-bit register port with printed register offsets
// Notes:   Status and mask of the interrupt sit just above the serial block
package tbam_pkg;

    // Register port request travels as one bundle
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tbam_bus_req_t;

    // Register offsets
    localparam logic [15:0] OFS_RCV      = 16'h0200;
    localparam logic [15:0] OFS_TRN      = 16'h0202;
    localparam logic [15:0] OFS_BRG      = 16'h0204;
    localparam logic [15:0] OFS_CON      = 16'h0206;
    localparam logic [15:0] OFS_STAT     = 16'h0208;
    localparam logic [15:0] OFS_ADDR     = 16'h020A;
    localparam logic [15:0] OFS_IRQ_STAT = 16'h020C;
    localparam logic [15:0] OFS_IRQ_MASK = 16'h020E;

    // Reset values and the control write mask
    localparam logic [15:0] RST_TRN  = 16'h00FF;
    localparam logic [15:0] RST_CON  = 16'h1000;
    localparam logic [15:0] CON_WMSK = 16'hBFFF;

    // Control field positions
    localparam int unsigned CON_EN  = 15;
    localparam int unsigned CON_A10 = 10;

    // Status field positions
    localparam int unsigned ST_FULL = 8;
    localparam int unsigned ST_OV   = 6;
    localparam int unsigned ST_DA   = 5;
    localparam int unsigned ST_P    = 4;
    localparam int unsigned ST_S    = 3;
    localparam int unsigned ST_RW   = 2;
    localparam int unsigned ST_RBF  = 1;
    localparam int unsigned ST_TBF  = 0;

    // Interrupt status positions
    localparam int unsigned IRQ_EVT = 0;
    localparam int unsigned IRQ_OV  = 1;

    // Fixed upper five bits of a ten-bit first address byte
    localparam logic [4:0] TEN_PREFIX = 5'h1E;
    localparam logic [3:0] BITS_BYTE  = 4'h8;
    localparam logic [3:0] BITS_LAST  = 4'h7;

    // Link states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_ACK   = 7'h04,
        ST_LOW   = 7'h08,
        ST_RX    = 7'h10,
        ST_TX    = 7'h20,
        ST_TXACK = 7'h40
    } tbam_state_t;

endpackage

// *** core/tbam_slave.sv ***
// Purpose: Two-wire slave address match, 7 and 10 bit, with register map
// Assumes: scl_i and sda_i are asynchronous; clk_sys_i far faster than scl
// Notes:   No clock stretching; data bytes follow the 7-bit path
`timescale 1ns/100ps
module tbam_slave
    import tbam_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic          rst_n_i,
    input  wire tbam_bus_req_t bus_i,
    output logic [15:0]        rdata_o,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe_n_o,
    output logic               irq_o
);

    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic        scl_f;
    logic        sda_f;
    logic        next_scl;
    logic        next_sda;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        go;
    logic        byte_end;
    tbam_state_t state;
    tbam_state_t ack_to;
    logic [3:0]  cnt;
    logic [7:0]  shreg;
    logic [7:0]  tx_sh;
    logic        sda_drv;
    logic        mack;
    logic        evt;
    logic        full_match;
    logic        rw_flag;
    logic        da_flag;
    logic        s_flag;
    logic        p_flag;
    logic [15:0] ctrl;
    logic [15:0] brg;
    logic [7:0]  trn;
    logic        tbf;
    logic [7:0]  rcv;
    logic        rbf;
    logic        ov;
    logic [9:0]  saddr;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [1:0]  next_irq_stat;
    logic        en;
    logic        a10;
    logic        match7;
    logic        match_hi;
    logic        match_lo;
    logic        rx_done;
    logic        tx_load;
    logic        ov_set;
    logic [15:0] stat_word;

    // Three-stage synchronisers on the serial pins
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_i};
            sda_s <= {sda_s[1:0], sda_i};
        end
    end

    // A level counts once stages two and three agree
    assign next_scl = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
    assign next_sda = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            scl_f <= next_scl;
            sda_f <= next_sda;
        end
    end

    // Bus edges and conditions
    assign scl_rise = next_scl & ~scl_f;
    assign scl_fall = ~next_scl & scl_f;
    assign start_c  = scl_f & next_scl & sda_f & ~next_sda;
    assign stop_c   = scl_f & next_scl & ~sda_f & next_sda;
    assign en       = ctrl[CON_EN];
    assign a10      = ctrl[CON_A10];
    assign go       = en & ~start_c & ~stop_c;
    assign byte_end = go & scl_fall & (cnt == BITS_BYTE);

    // Address comparators
    assign match7   = ~a10 & (shreg[7:1] == saddr[6:0]);
    assign match_hi = a10 & (shreg[7:3] == TEN_PREFIX)
                    & (shreg[2:1] == saddr[9:8]) & ~shreg[0];
    assign match_lo = (shreg == saddr[7:0]);

    // Strobes toward the data buffers
    assign rx_done = byte_end & (state == ST_RX);
    assign ov_set  = rx_done & rbf;
    assign tx_load = go & scl_fall
                   & (((state == ST_ACK) & (ack_to == ST_TX))
                   | ((state == ST_TXACK) & mack));

    // Link state machine
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state      <= ST_IDLE;
            ack_to     <= ST_IDLE;
            cnt        <= 4'h0;
            shreg      <= 8'h00;
            tx_sh      <= 8'h00;
            sda_drv    <= 1'b0;
            mack       <= 1'b0;
            evt        <= 1'b0;
            full_match <= 1'b0;
            rw_flag    <= 1'b0;
            da_flag    <= 1'b0;
            s_flag     <= 1'b0;
            p_flag     <= 1'b0;
        end else begin
            evt <= 1'b0;
            if (!en || stop_c) begin
                state   <= ST_IDLE;
                sda_drv <= 1'b0;
                if (stop_c) begin
                    p_flag <= 1'b1;
                    s_flag <= 1'b0;
                end
            end else if (start_c) begin
                state   <= ST_ADDR;
                cnt     <= 4'h0;
                sda_drv <= 1'b0;
                s_flag  <= 1'b1;
                p_flag  <= 1'b0;
            end else begin
                unique case (state)
                    ST_IDLE: begin
                        cnt <= 4'h0;
                    end
                    ST_ADDR, ST_LOW, ST_RX: begin
                        if (scl_rise && cnt < BITS_BYTE) begin
                            shreg <= {shreg[6:0], next_sda};
                            cnt   <= cnt + 4'h1;
                        end else if (byte_end) begin
                            if (state == ST_ADDR && a10) begin
                                full_match <= 1'b0;
                                rw_flag    <= shreg[0];
                                da_flag    <= 1'b0;
                                sda_drv    <= match_hi;
                                ack_to     <= ST_LOW;
                                state <= match_hi ? ST_ACK
                                                  : ST_IDLE;
                            end else if (state == ST_ADDR) begin
                                rw_flag <= shreg[0];
                                da_flag <= 1'b0;
                                sda_drv <= match7;
                                ack_to  <= shreg[0] ? ST_TX : ST_RX;
                                state   <= match7 ? ST_ACK : ST_IDLE;
                            end else if (state == ST_LOW) begin
                                full_match <= match_lo;
                                sda_drv    <= match_lo;
                                ack_to     <= ST_RX;
                                state <= match_lo ? ST_ACK
                                                  : ST_IDLE;
                            end else begin
                                da_flag <= 1'b1;
                                sda_drv <= ~rbf;
                                ack_to  <= ST_RX;
                                state   <= ST_ACK;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (go && scl_fall) begin
                            evt   <= 1'b1;
                            cnt   <= 4'h0;
                            state <= ack_to;
                            if (ack_to == ST_TX) begin
                                tx_sh   <= {trn[6:0], 1'b0};
                                sda_drv <= ~trn[7];
                            end else begin
                                sda_drv <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (go && scl_fall) begin
                            if (cnt == BITS_LAST) begin
                                sda_drv <= 1'b0;
                                state   <= ST_TXACK;
                            end else begin
                                sda_drv <= ~tx_sh[7];
                                tx_sh   <= {tx_sh[6:0], 1'b0};
                                cnt     <= cnt + 4'h1;
                            end
                        end
                    end
                    ST_TXACK: begin
                        if (scl_rise) begin
                            mack <= ~next_sda;
                        end else if (go && scl_fall) begin
                            evt   <= 1'b1;
                            cnt   <= 4'h0;
                            state <= mack ? ST_TX : ST_IDLE;
                            tx_sh   <= {trn[6:0], 1'b0};
                            sda_drv <= mack & ~trn[7];
                        end
                    end
                endcase
            end
        end
    end

    // Open-drain data pin: pull low only, enable is active low
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sda_o      <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else begin
            sda_o      <= 1'b0;
            sda_oe_n_o <= ~sda_drv;
        end
    end

    // Receive buffer, full flag and overflow; hardware set beats clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rcv <= 8'h00;
            rbf <= 1'b0;
            ov  <= 1'b0;
        end else begin
            if (rx_done && !rbf) begin
                rcv <= shreg;
                rbf <= 1'b1;
            end else if (bus_i.rd && bus_i.addr == OFS_RCV) begin
                rbf <= 1'b0;
            end
            if (ov_set) begin
                ov <= 1'b1;
            end else if (bus_i.wr && bus_i.addr == OFS_STAT) begin
                ov <= bus_i.wdata[ST_OV];
            end
        end
    end

    // Software-written registers
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl     <= RST_CON;
            brg      <= 16'h0000;
            trn      <= RST_TRN[7:0];
            tbf      <= 1'b0;
            saddr    <= 10'h000;
            irq_mask <= 2'h0;
        end else begin
            if (bus_i.wr) begin
                unique case (bus_i.addr)
                    OFS_CON:      ctrl     <= bus_i.wdata & CON_WMSK;
                    OFS_BRG:      brg      <= bus_i.wdata;
                    OFS_TRN:      trn      <= bus_i.wdata[7:0];
                    OFS_ADDR:     saddr    <= bus_i.wdata[9:0];
                    OFS_IRQ_MASK: irq_mask <= bus_i.wdata[1:0];
                    default:      ;
                endcase
            end
            // A new byte written as the old one is taken stays pending
            if (bus_i.wr && bus_i.addr == OFS_TRN) begin
                tbf <= 1'b1;
            end else if (tx_load) begin
                tbf <= 1'b0;
            end
        end
    end

    // Status word as software sees it
    always_comb begin
        stat_word          = 16'h0000;
        stat_word[ST_FULL] = full_match;
        stat_word[ST_OV]   = ov;
        stat_word[ST_DA]   = da_flag;
        stat_word[ST_P]    = p_flag;
        stat_word[ST_S]    = s_flag;
        stat_word[ST_RW]   = rw_flag;
        stat_word[ST_RBF]  = rbf;
        stat_word[ST_TBF]  = tbf;
    end

    // Sticky interrupt causes, cleared by reading them; new events win
    always_comb begin
        next_irq_stat = irq_stat;
        if (bus_i.rd && bus_i.addr == OFS_IRQ_STAT) begin
            next_irq_stat = 2'h0;
        end
        next_irq_stat[IRQ_EVT] = next_irq_stat[IRQ_EVT] | evt;
        next_irq_stat[IRQ_OV]  = next_irq_stat[IRQ_OV] | ov_set;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            irq_stat <= 2'h0;
            irq_o    <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_o    <= |(next_irq_stat & irq_mask);
        end
    end

    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                OFS_RCV:      rdata_o <= {8'h00, rcv};
                OFS_TRN:      rdata_o <= {8'h00, trn};
                OFS_BRG:      rdata_o <= brg;
                OFS_CON:      rdata_o <= ctrl;
                OFS_STAT:     rdata_o <= stat_word;
                OFS_ADDR:     rdata_o <= {6'h00, saddr};
                OFS_IRQ_STAT: rdata_o <= {14'h0000, irq_stat};
                OFS_IRQ_MASK: rdata_o <= {14'h0000, irq_mask};
                default:      rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_hi_end;
        state == ST_ADDR && byte_end && a10;
    endsequence

    sequence s_lo_end;
        state == ST_LOW && byte_end;
    endsequence

    property p_hi_match;
        s_hi_end and match_hi |=> state == ST_ACK && !full_match
            ##1 !sda_oe_n_o;
    endproperty
    a_hi_match: assert property (p_hi_match)
        else $error("first ten-bit byte match not acknowledged");

    property p_hi_fail;
        s_hi_end and !match_hi |=> state == ST_IDLE && !full_match
            ##1 sda_oe_n_o;
    endproperty
    a_hi_fail: assert property (p_hi_fail)
        else $error("first byte mismatch did not return to idle");

    property p_lo_match;
        s_lo_end and match_lo |=> full_match && state == ST_ACK;
    endproperty
    a_lo_match: assert property (p_lo_match)
        else $error("second byte match did not set full match");

    property p_lo_fail;
        s_lo_end and !match_lo |=> !full_match ##1 sda_oe_n_o;
    endproperty
    a_lo_fail: assert property (p_lo_fail)
        else $error("second byte mismatch was acknowledged");

    property p_seven;
        state == ST_ADDR && byte_end && !a10
            && shreg[7:1] == saddr[6:0] |=> state == ST_ACK;
    endproperty
    a_seven: assert property (p_seven)
        else $error("seven-bit address match missed");

    property p_shift;
        (state == ST_LOW || state == ST_ADDR) && go && scl_rise
            && cnt < BITS_BYTE |=> shreg[0] == $past(next_sda);
    endproperty
    a_shift: assert property (p_shift)
        else $error("bit not sampled on rising serial clock");

    property p_evt;
        state == ST_ACK && go && scl_fall |=> evt ##1 irq_stat[IRQ_EVT];
    endproperty
    a_evt: assert property (p_evt)
        else $error("event not raised on ninth falling edge");

    property p_rx;
        rx_done && !rbf |=> rbf && rcv == $past(shreg);
    endproperty
    a_rx: assert property (p_rx)
        else $error("received byte not loaded");

    property p_addr_rd;
        bus_i.rd && bus_i.addr == OFS_ADDR |=> rdata_o[15:10] == 6'h00
            && rdata_o[9:0] == saddr;
    endproperty
    a_addr_rd: assert property (p_addr_rd)
        else $error("address read back wrong");

endmodule // tbam_slave

// *** bench/tbam_master.sv ***
// Purpose: Behavioural two-wire bus master that addresses the slave
// Assumes: Open-drain lines with pull-ups; 1 on an output means released
// Notes:   Serial clock runs only inside frames, period 200 ns, high 50 ns
`timescale 1ns/100ps
module tbam_master (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_line_i
);
    localparam int Q = 50;

    // Both lines idle released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Start: data falls while clock is high, odd offset breaks phase
    task automatic start_cond();
        #7;
        sda_o = 1'b1;
        scl_o = 1'b1;
        #(2*Q);
        sda_o = 1'b0;
        #(2*Q);
        scl_o = 1'b0;
        #Q;
    endtask

    // One bit: data set in the low phase, line sampled mid-high.
    // The long low phase gives the slave time to answer through its
    // synchroniser before the clock rises again
    task automatic bit_clk(input logic d, output logic s);
        sda_o = d;
        #(2*Q);
        scl_o = 1'b1;
        #(Q/2);
        s = sda_line_i;
        #(Q/2);
        scl_o = 1'b0;
        #Q;
    endtask

    // Eight bits MSB first, then samples the acknowledge bit
    task automatic send_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(b[i], s);
        end
        bit_clk(1'b1, ack_n);
    endtask

    // Eight bits read MSB first, then the master's own acknowledge
    task automatic recv_byte(input logic ack_n, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_clk(1'b1, s);
            b[i] = s;
        end
        bit_clk(ack_n, s);
    endtask

    // Stop: data rises while clock is high, clock then stands still
    task automatic stop_cond();
        sda_o = 1'b0;
        #Q;
        scl_o = 1'b1;
        #(2*Q);
        sda_o = 1'b1;
        #(2*Q);
    endtask
endmodule // tbam_master

// *** bench/testbench.sv ***
// Purpose: Self-checking bench of the ten-bit address match slave
// Assumes: Master model drives the serial lines, bench drives the registers
// Notes:   Random addresses from a fixed seed, corner cases by hand
`timescale 1ns/100ps
module testbench;
    import tbam_pkg::*;

    logic          clk_sys_i;
    logic          rst_n_i;
    tbam_bus_req_t bus;
    logic [15:0]   rdata_o;
    logic          sda_dev;
    logic          sda_oe_n_o;
    logic          irq_o;
    logic          m_scl;
    logic          m_sda;
    logic          mask_v;
    int            err_total;
    int            compares;
    int            cyc;
    int            seed;
    logic [9:0]    a10;
    logic [6:0]    a7;
    logic [7:0]    b1;
    logic [7:0]    bad;
    logic [7:0]    dat;
    logic [7:0]    rbyte;
    logic [15:0]   v;
    logic [15:0]   ofs [8];
    logic [15:0]   rst_v [8];
    // Pull-up line: low when either party pulls low
    wire           sda_line = m_sda & (sda_oe_n_o | sda_dev);

    tbam_slave i_tbam_slave (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .bus_i      (bus),
        .rdata_o    (rdata_o),
        .scl_i      (m_scl),
        .sda_i      (sda_line),
        .sda_o      (sda_dev),
        .sda_oe_n_o (sda_oe_n_o),
        .irq_o      (irq_o)
    );

    tbam_master i_tbam_master (
        .scl_o      (m_scl),
        .sda_o      (m_sda),
        .sda_line_i (sda_line)
    );

    // System clock, 25 ns period
    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Cycle ceiling cuts a hang short
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] got, exp, input string msg);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, d);
        @(posedge clk_sys_i);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1 d = rdata_o;
    endtask

    // One byte with acknowledge, event and full-match expectations
    task automatic byte_chk(input logic [7:0] b, input logic ea, ef);
        logic        ack_n;
        logic [15:0] r;
        i_tbam_master.send_byte(b, ack_n);
        chk({15'h0, ack_n}, {15'h0, ~ea}, "ack");
        repeat (8) @(posedge clk_sys_i);
        #1 chk({15'h0, irq_o}, {15'h0, ea & mask_v}, "irq");
        rd_reg(OFS_IRQ_STAT, r);
        chk(r, {15'h0, ea}, "event");
        rd_reg(OFS_STAT, r);
        chk({15'h0, r[ST_FULL]}, {15'h0, ef}, "full");
    endtask

    initial begin
        seed      = 32'hae3c;
        err_total = 0;
        compares  = 0;
        cyc       = 0;
        mask_v    = 1'b1;
        bus       = '0;
        rst_n_i   = 1'b0;
        ofs   = '{OFS_RCV, OFS_TRN, OFS_BRG, OFS_CON, OFS_STAT, OFS_ADDR,
                  OFS_IRQ_STAT, OFS_IRQ_MASK};
        rst_v = '{16'h0000, RST_TRN, 16'h0000, RST_CON, 16'h0000,
                  16'h0000, 16'h0000, 16'h0000};
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // Reset values, unused bits and unmapped places
        for (int i = 0; i < 8; i++) begin
            rd_reg(ofs[i], v);
            chk(v, rst_v[i], "reset value");
        end
        wr_reg(OFS_ADDR, 16'hFFFF);
        rd_reg(OFS_ADDR, v);
        chk(v, 16'h03FF, "address width");
        wr_reg(OFS_TRN, 16'hFFFF);
        rd_reg(OFS_TRN, v);
        chk(v, 16'h00FF, "transmit width");
        wr_reg(OFS_CON, 16'hFFFF);
        rd_reg(OFS_CON, v);
        chk(v, CON_WMSK, "control width");
        wr_reg(OFS_RCV, 16'h1234);
        rd_reg(OFS_RCV, v);
        chk(v, 16'h0000, "receive read only");
        wr_reg(16'h0210, 16'hFFFF);
        rd_reg(16'h0210, v);
        chk(v, 16'h0000, "unmapped");
        $display("test registers done");
        // Ten-bit full match followed by a data byte
        a10 = 10'($random(seed));
        dat = 8'($random(seed));
        b1  = {TEN_PREFIX, a10[9:8], 1'b0};
        wr_reg(OFS_CON, 16'h8400);
        wr_reg(OFS_ADDR, {6'h00, a10});
        wr_reg(OFS_IRQ_MASK, 16'h0001);
        rd_reg(OFS_IRQ_STAT, v);
        i_tbam_master.start_cond();
        byte_chk(b1, 1'b1, 1'b0);
        byte_chk(a10[7:0], 1'b1, 1'b1);
        byte_chk(dat, 1'b1, 1'b1);
        i_tbam_master.stop_cond();
        rd_reg(OFS_RCV, v);
        chk(v, {8'h00, dat}, "received data");
        $display("test ten-bit match done");
        // Prefix, upper bits, read bit and low byte mismatches
        for (int i = 0; i < 4; i++) begin
            bad = (i == 0) ? b1 ^ 8'h80 : (i == 1) ? b1 ^ 8'h02 :
                  (i == 2) ? b1 | 8'h01 : b1;
            i_tbam_master.start_cond();
            byte_chk(bad, i == 3, 1'b0);
            byte_chk(a10[7:0] ^ ((i == 3) ? 8'h10 : 8'h00), 1'b0,
                     1'b0);
            i_tbam_master.stop_cond();
        end
        $display("test ten-bit mismatch done");
        // Seven-bit mode, interrupt masked
        a7 = 7'h04 + 7'($random(seed) & 32'h3f);
        mask_v = 1'b0;
        wr_reg(OFS_IRQ_MASK, 16'h0000);
        wr_reg(OFS_CON, 16'h8000);
        wr_reg(OFS_ADDR, {9'h000, a7});
        i_tbam_master.start_cond();
        byte_chk({a7, 1'b0}, 1'b1, 1'b0);
        i_tbam_master.stop_cond();
        i_tbam_master.start_cond();
        byte_chk({a7 ^ 7'h01, 1'b0}, 1'b0, 1'b0);
        i_tbam_master.stop_cond();
        // Seven-bit read: slave shifts the transmit byte out
        dat = 8'($random(seed));
        wr_reg(OFS_TRN, {8'h00, dat});
        i_tbam_master.start_cond();
        byte_chk({a7, 1'b1}, 1'b1, 1'b0);
        i_tbam_master.recv_byte(1'b1, rbyte);
        i_tbam_master.stop_cond();
        chk({8'h00, rbyte}, {8'h00, dat}, "sent data");
        rd_reg(OFS_IRQ_STAT, v);
        chk(v, 16'h0001, "event after read byte");
        rd_reg(OFS_STAT, v);
        chk({15'h0, v[ST_TBF]}, 16'h0000, "tx buffer");
        // Same byte refused once ten-bit select is set
        wr_reg(OFS_CON, 16'h8400);
        i_tbam_master.start_cond();
        byte_chk({a7, 1'b0}, 1'b0, 1'b0);
        i_tbam_master.stop_cond();
        $display("test seven-bit mode done");
        final_report();
    end
endmodule // testbench
